//--- src/bldc_commutation_protection_logic.sv
// Top level of the three-phase brushless motor commutation, chopping and protection logic.
// Functional notes
// - With rectification on, off-time switches on the transistors carrying decay current.
// - Dead-time gap between any gate turn-off and the next turn-on.
// - With rectification on, body diodes conduct only within the dead-time gap.
// - High side waits after bootstrap charge until charge current is low; no fault.
// - Selected high side may stay on indefinitely at full duty.
// - Hall code 000 or 111 raises fault and coasts the motor.
// - Undervoltage forces every gate low until the supply recovers.
// - Over-temperature raises fault and coasts; clears when indication drops.
// - Excess high-side drain-source voltage after turn-on raises short-to-ground fault.
// - Latched short-to-ground fault clears at each new commutation step.
// - Stalled short fault clears only by reset toggle or power-up.
// - Comparator trip clears source enable, high side off, off time starts.
// - Decay select and rectification choose the recirculation transistors.
// - Off time is a settable duration, about 10 to 50 microseconds.
// - At end of off time the selected high side turns back on.
// - Comparator ignored for a blanking interval after each turn-on from all high sides off.
// - Active-low brake turns on all low sides and off all high sides.
// - Reset input high overrides brake and coasts the motor.
// - Hall code and direction select the high and low phase pair.
// - Fault output for bad Hall, undervoltage, thermal or short to ground.
// - Short fault turns off high sides only and is the only latched fault.
// - Slow decay turns off only the high side; fast decay turns off both.
`timescale 1ns/1ps
`default_nettype none

module bldc_commutation_protection_logic #(
	parameter int TMR_W = bldc_ctrl_pkg::TMR_W
) (
	// Clock and reset.
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	// Motor commands from the host.
	input  wire logic [2:0]             hall_inputs_i,
	input  wire logic                   dir_i,
	input  wire logic                   pwm_i,
	input  wire logic                   decay_slow_i,
	input  wire logic                   sync_rectify_enable_i,
	input  wire logic                   brake_n_i,
	input  wire logic                   coast_reset_i,
	// Interval configuration.
	input  wire bldc_ctrl_pkg::timing_t timing_i,
	// Analog indications, already digital.
	input  wire logic                   current_trip_i,
	input  wire logic                   undervolt_i,
	input  wire logic                   overtemp_i,
	input  wire logic                   high_vds_over_i,
	input  wire logic                   boot_charge_busy_i,
	// Gate drives and status.
	output logic [2:0]                  high_gate_drive_o,
	output logic [2:0]                  low_gate_drive_o,
	output logic                        fault_o,
	output bldc_ctrl_pkg::fault_t       fault_src_o,
	output logic                        speed_pulse_out_o
);

	// Hall synchroniser: the first stage is read only by the second.
	logic [2:0] hall_s1_ff;
	logic [2:0] hall_s2_ff;
	logic [2:0] hall_ff;
	logic [2:0] nxt_hall_s1;
	logic [2:0] nxt_hall_s2;
	logic [2:0] nxt_hall;

	always_comb begin
		nxt_hall_s1 = hall_inputs_i;
		nxt_hall_s2 = hall_s1_ff;
		nxt_hall    = hall_s2_ff;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hall_s1_ff <= 3'h0;
			hall_s2_ff <= 3'h0;
			hall_ff    <= 3'h0;
		end else begin
			hall_s1_ff <= nxt_hall_s1;
			hall_s2_ff <= nxt_hall_s2;
			hall_ff    <= nxt_hall;
		end
	end

	// A commutation step is any change of the synchronised Hall code.
	logic step;
	assign step = (hall_s2_ff != hall_ff);

	// Decode of Hall code to one-hot high and low phase; forward direction table.
	function automatic logic [5:0] commutate(input logic [2:0] h, input logic d);
		logic [2:0] hi;
		logic [2:0] lo;
		hi = 3'h0;
		lo = 3'h0;
		case (h)
			3'h5: begin hi = 3'h1; lo = 3'h4; end
			3'h4: begin hi = 3'h2; lo = 3'h4; end
			3'h6: begin hi = 3'h2; lo = 3'h1; end
			3'h2: begin hi = 3'h4; lo = 3'h1; end
			3'h3: begin hi = 3'h4; lo = 3'h2; end
			3'h1: begin hi = 3'h1; lo = 3'h2; end
			default: begin hi = 3'h0; lo = 3'h0; end
		endcase
		// Reverse direction swaps the roles of the pair.
		return d ? {hi, lo} : {lo, hi};
	endfunction

	logic [2:0] sel_hi;
	logic [2:0] sel_lo;
	logic       hall_bad;
	assign {sel_hi, sel_lo} = commutate(hall_ff, dir_i);
	assign hall_bad = (hall_ff == bldc_ctrl_pkg::HALL_ALL_LOW) ||
		(hall_ff == bldc_ctrl_pkg::HALL_ALL_HIGH);

	// Chopping state, off-time counter and blanking counter.
	bldc_ctrl_pkg::chop_t chop_ff;
	bldc_ctrl_pkg::chop_t nxt_chop;
	logic [TMR_W-1:0]     off_cnt_ff;
	logic [TMR_W-1:0]     nxt_off_cnt;
	logic [TMR_W-1:0]     blank_cnt_ff;
	logic [TMR_W-1:0]     nxt_blank_cnt;
	logic                 hs_on_prev_ff;
	logic                 nxt_hs_on_prev;
	logic                 hs_on_now;
	logic                 hs_rise;

	// The high side counts as on when the gate actually reaches the bridge.
	assign hs_on_now = |high_gate_drive_o;
	assign hs_rise   = hs_on_now & ~hs_on_prev_ff;

	// Fixed off-time chopper; the comparator only acts once blanking has run out.
	always_comb begin
		nxt_chop       = chop_ff;
		nxt_off_cnt    = off_cnt_ff;
		nxt_blank_cnt  = blank_cnt_ff;
		nxt_hs_on_prev = hs_on_now;
		if (hs_rise) begin
			nxt_blank_cnt = timing_i.blank_cyc;
		end else if (blank_cnt_ff != '0) begin
			nxt_blank_cnt = blank_cnt_ff - 1'b1;
		end
		case (chop_ff)
			bldc_ctrl_pkg::CHOP_ON: begin
				if (current_trip_i && blank_cnt_ff == '0 && !hs_rise && hs_on_now) begin
					nxt_chop    = bldc_ctrl_pkg::CHOP_OFF;
					nxt_off_cnt = timing_i.off_cyc;
				end
			end
			bldc_ctrl_pkg::CHOP_OFF: begin
				if (off_cnt_ff <= {{(TMR_W-1){1'b0}}, 1'b1}) begin
					nxt_chop    = bldc_ctrl_pkg::CHOP_ON;
					nxt_off_cnt = '0;
				end else begin
					nxt_off_cnt = off_cnt_ff - 1'b1;
				end
			end
			default: begin
				nxt_chop    = bldc_ctrl_pkg::CHOP_ON;
				nxt_off_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			chop_ff       <= bldc_ctrl_pkg::CHOP_ON;
			off_cnt_ff    <= '0;
			blank_cnt_ff  <= '0;
			hs_on_prev_ff <= 1'b0;
		end else begin
			chop_ff       <= nxt_chop;
			off_cnt_ff    <= nxt_off_cnt;
			blank_cnt_ff  <= nxt_blank_cnt;
			hs_on_prev_ff <= nxt_hs_on_prev;
		end
	end

	// Short-to-ground latch: set after a high side is on and its drain-source voltage is high.
	// Set wins over the step clear; coast_reset clears it, so a stalled motor recovers only that way.
	logic short_ff;
	logic nxt_short;
	logic short_set;
	assign short_set = hs_on_prev_ff & hs_on_now & high_vds_over_i;

	always_comb begin
		nxt_short = short_ff;
		if (short_set) begin
			nxt_short = 1'b1;
		end else if (coast_reset_i) begin
			nxt_short = 1'b0;
		end else if (step) begin
			nxt_short = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			short_ff <= 1'b0;
		end else begin
			short_ff <= nxt_short;
		end
	end

	// Requested gates before dead time; priorities: coast causes, brake, short fault, normal run.
	logic                 coast;
	logic                 pwm_off;
	bldc_ctrl_pkg::gate_t req;

	assign coast   = coast_reset_i | undervolt_i | overtemp_i | hall_bad;
	assign pwm_off = ~pwm_i | (chop_ff == bldc_ctrl_pkg::CHOP_OFF);

	always_comb begin
		req.high_gate_drive = 3'h0;
		req.low_gate_drive  = 3'h0;
		if (coast) begin
			req.high_gate_drive = 3'h0;
			req.low_gate_drive  = 3'h0;
		end else if (!brake_n_i) begin
			req.low_gate_drive  = 3'h7;
		end else if (!pwm_off) begin
			req.high_gate_drive = sel_hi;
			req.low_gate_drive  = sel_lo;
		end else begin
			// Decay path chosen by decay select and rectification.
			case ({decay_slow_i, sync_rectify_enable_i})
				2'b10: req.low_gate_drive = sel_lo;
				2'b11: req.low_gate_drive = sel_lo | sel_hi;
				2'b01: begin
					req.high_gate_drive = sel_lo;
					req.low_gate_drive  = sel_hi;
				end
				default: req.low_gate_drive = 3'h0;
			endcase
		end
		// Short fault drops high sides only; bootstrap charge defers high-side turn-on silently.
		if (short_ff) begin
			req.high_gate_drive = 3'h0;
		end
		if (boot_charge_busy_i) begin
			req.high_gate_drive = req.high_gate_drive & high_gate_drive_o;
		end
	end

	// Dead-time insertion on every leg.
	logic [2:0] dt_hi;
	logic [2:0] dt_lo;

	gate_dead_time #(
		.TMR_W(TMR_W)
	) u_dead (
		.clk_i            (clk_i),
		.rstn_i           (rstn_i),
		.req_i            (req),
		.dead_cyc_i       (timing_i.dead_cyc),
		.high_gate_drive_o(dt_hi),
		.low_gate_drive_o (dt_lo)
	);

	// Undervoltage also gates the outputs directly so no stale gate survives a supply dip.
	assign high_gate_drive_o = undervolt_i ? 3'h0 : dt_hi;
	assign low_gate_drive_o  = undervolt_i ? 3'h0 : dt_lo;

	// Fault flags and speed pulse, registered.
	bldc_ctrl_pkg::fault_t fsrc_ff;
	bldc_ctrl_pkg::fault_t nxt_fsrc;
	logic                  fault_ff;
	logic                  nxt_fault;
	logic                  speed_pulse_out_ff;
	logic                  nxt_speed_pulse_out;

	always_comb begin
		nxt_fsrc.hall_bad  = hall_bad;
		nxt_fsrc.undervolt = undervolt_i;
		nxt_fsrc.overtemp  = overtemp_i;
		nxt_fsrc.short_gnd = nxt_short;
		nxt_fault = hall_bad | undervolt_i | overtemp_i | nxt_short;
		nxt_speed_pulse_out  = step;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fsrc_ff  <= '0;
			fault_ff <= 1'b0;
			speed_pulse_out_ff  <= 1'b0;
		end else begin
			fsrc_ff  <= nxt_fsrc;
			fault_ff <= nxt_fault;
			speed_pulse_out_ff  <= nxt_speed_pulse_out;
		end
	end

	assign fault_o           = fault_ff;
	assign fault_src_o       = fsrc_ff;
	assign speed_pulse_out_o = speed_pulse_out_ff;

endmodule
`default_nettype wire

//--- src/bldc_ctrl_pkg.sv
// Package with constants and carrier types for the brushless motor commutation and protection logic.
package bldc_ctrl_pkg;

	// Logic clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 100;

	// Dead-time range limits as printed, in nanoseconds.
	localparam int DEAD_MIN_NS = 100;
	localparam int DEAD_MAX_NS = 5500;
	localparam int DEAD_MIN_CYC = (DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_MAX_CYC = DEAD_MAX_NS / CLK_PERIOD_NS;

	// Off-time range limits, in microseconds.
	localparam int OFF_MIN_US = 10;
	localparam int OFF_MAX_US = 50;
	localparam int OFF_MIN_CYC = (OFF_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_MAX_CYC = (OFF_MAX_US * 1000) / CLK_PERIOD_NS;

	// Counter width for all interval timers.
	localparam int TMR_W = 12;

	// Reset values of the interval configurations, in cycles.
	localparam logic [TMR_W-1:0] DEAD_RST = 12'h00a;
	localparam logic [TMR_W-1:0] OFF_RST  = 12'h0c8;
	localparam logic [TMR_W-1:0] BLANK_RST = 12'h014;

	// Illegal hall codes.
	localparam logic [2:0] HALL_ALL_LOW  = 3'h0;
	localparam logic [2:0] HALL_ALL_HIGH = 3'h7;

	// Gate drive group: one bit per phase A, B, C (bit 0 is A).
	typedef struct packed {
		logic [2:0] high_gate_drive;
		logic [2:0] low_gate_drive;
	} gate_t;

	// Interval configuration, standing in for the external networks.
	typedef struct packed {
		logic [TMR_W-1:0] dead_cyc;
		logic [TMR_W-1:0] off_cyc;
		logic [TMR_W-1:0] blank_cyc;
	} timing_t;

	// Fault sources reported on the status port.
	typedef struct packed {
		logic hall_bad;
		logic undervolt;
		logic overtemp;
		logic short_gnd;
	} fault_t;

	// Chopping phase states.
	typedef enum logic [1:0] {
		CHOP_ON    = 2'b00,
		CHOP_OFF   = 2'b01
	} chop_t;

endpackage

//--- src/gate_dead_time.sv
// Per-gate dead-time inserter: delays each turn-on until all gates of its leg have been off long enough.
`timescale 1ns/1ps
`default_nettype none

module gate_dead_time #(
	parameter int TMR_W = bldc_ctrl_pkg::TMR_W
) (
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	// Requested gates and dead-time length.
	input  wire bldc_ctrl_pkg::gate_t req_i,
	input  wire logic [TMR_W-1:0]     dead_cyc_i,
	// Gates as driven to the bridge.
	output logic [2:0]                high_gate_drive_o,
	output logic [2:0]                low_gate_drive_o
);

	logic [2:0]       hi_ff;
	logic [2:0]       lo_ff;
	logic [2:0]       nxt_hi;
	logic [2:0]       nxt_lo;
	logic [TMR_W-1:0] cnt_ff [3];
	logic [TMR_W-1:0] nxt_cnt [3];

	// Each leg has its own counter, restarted whenever any gate of the leg is off-to-idle.
	// Turn-off is immediate; turn-on waits for the counter so both switches never overlap.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			nxt_hi[i] = req_i.high_gate_drive[i] & hi_ff[i];
			nxt_lo[i] = req_i.low_gate_drive[i] & lo_ff[i];
			nxt_cnt[i] = cnt_ff[i];
			if (nxt_hi[i] == hi_ff[i] && nxt_lo[i] == lo_ff[i] && (hi_ff[i] | lo_ff[i])) begin
				nxt_cnt[i] = '0;
			end else if (hi_ff[i] != nxt_hi[i] || lo_ff[i] != nxt_lo[i]) begin
				nxt_cnt[i] = '0;
			end else if (cnt_ff[i] < dead_cyc_i) begin
				nxt_cnt[i] = cnt_ff[i] + 1'b1;
			end else if (req_i.high_gate_drive[i] & ~req_i.low_gate_drive[i]) begin
				nxt_hi[i] = 1'b1;
			end else if (req_i.low_gate_drive[i] & ~req_i.high_gate_drive[i]) begin
				nxt_lo[i] = 1'b1;
			end
		end
	end

	// Registers for gates and counters.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hi_ff <= 3'h0;
			lo_ff <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				cnt_ff[i] <= '0;
			end
		end else begin
			hi_ff <= nxt_hi;
			lo_ff <= nxt_lo;
			for (int i = 0; i < 3; i++) begin
				cnt_ff[i] <= nxt_cnt[i];
			end
		end
	end

	assign high_gate_drive_o = hi_ff;
	assign low_gate_drive_o  = lo_ff;

endmodule
`default_nettype wire

//--- tb/bridge_model.sv
// Bridge model: reports high-side drain-source overvoltage and bootstrap charge current.
`timescale 1ns/1ps
`default_nettype none

module bridge_model #(
	parameter int BOOT_CYC = 3
) (
	// Clock, gates from the logic and the short the bench injects.
	input  wire logic       clk_i,
	input  wire logic [2:0] high_gate_drive_i,
	input  wire logic [2:0] low_gate_drive_i,
	input  wire logic       short_i,
	// Indications back to the logic.
	output logic            high_vds_over_o,
	output logic            boot_charge_busy_o
);
	logic [2:0] low_q = 3'h0;
	int         boot_cnt = 0;

	// A lead shorted to ground leaves the full supply across any high side that is on.
	assign high_vds_over_o = short_i & (|high_gate_drive_i);

	// Charge current flows for a few cycles after a low side closes, so a fast high side must wait.
	always @(posedge clk_i) begin
		low_q <= low_gate_drive_i;
		if (|(low_gate_drive_i & ~low_q)) begin
			boot_cnt <= BOOT_CYC;
		end else if (boot_cnt > 0) begin
			boot_cnt <= boot_cnt - 1;
		end
	end
	assign boot_charge_busy_o = (boot_cnt > 0);
endmodule
`default_nettype wire

//--- tb/bldc_ctrl_properties.sv
// Checker of the motor commutation and protection logic, bound to its top level.
`timescale 1ns/1ps
`default_nettype none

module bldc_ctrl_properties #(
	parameter int TMR_W = bldc_ctrl_pkg::TMR_W
) (
	// Design ports that the properties watch.
	input wire logic                   clk_i,
	input wire logic                   rstn_i,
	input wire logic                   pwm_i,
	input wire logic                   brake_n_i,
	input wire logic                   coast_reset_i,
	input wire bldc_ctrl_pkg::timing_t timing_i,
	input wire logic                   current_trip_i,
	input wire logic                   undervolt_i,
	input wire logic                   overtemp_i,
	input wire logic                   high_vds_over_i,
	input wire logic [2:0]             high_gate_drive_o,
	input wire logic [2:0]             low_gate_drive_o,
	input wire logic                   fault_o,
	input wire bldc_ctrl_pkg::fault_t  fault_src_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	logic [7:0] idle_ff [3];
	logic [7:0] on_ff;

	// Cycles each leg has been fully off and cycles a high side has been on; both saturate.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			idle_ff <= '{8'h00, 8'h00, 8'h00};
			on_ff   <= 8'h00;
		end else begin
			for (int i = 0; i < 3; i++) begin
				idle_ff[i] <= (high_gate_drive_o[i] | low_gate_drive_o[i]) ? 8'h00 : idle_ff[i] + {7'h00, ~&idle_ff[i]};
			end
			on_ff <= (high_gate_drive_o == 3'h0) ? 8'h00 : on_ff + {7'h00, ~&on_ff};
		end
	end

	// Each gate of a leg turns on only after the whole leg has been off for the dead time.
	for (genvar g = 0; g < 3; g++) begin : g_leg
		property p_dead;
			($rose(high_gate_drive_o[g]) || $rose(low_gate_drive_o[g])) |-> {4'h0, idle_ff[g]} >= timing_i.dead_cyc;
		endproperty
		a_dead: assert property (p_dead) else $error("Gate turned on inside the dead time");
	end

	property p_uv;
		undervolt_i |-> {high_gate_drive_o, low_gate_drive_o} == 6'h00;
	endproperty
	a_uv: assert property (p_uv) else $error("Gate on during undervoltage");
	property p_ot;
		overtemp_i [*3] |-> fault_o && fault_src_o.overtemp && {high_gate_drive_o, low_gate_drive_o} == 6'h00;
	endproperty
	a_ot: assert property (p_ot) else $error("Over-temperature did not coast");
	property p_brake;
		!brake_n_i [*3] |-> high_gate_drive_o == 3'h0;
	endproperty
	a_brake: assert property (p_brake) else $error("High side on while braking");
	property p_coast;
		coast_reset_i [*3] |-> {high_gate_drive_o, low_gate_drive_o} == 6'h00;
	endproperty
	a_coast: assert property (p_coast) else $error("Gate on while coasting");
	property p_trip;
		current_trip_i && pwm_i && {4'h0, on_ff} > timing_i.blank_cyc + 12'h003 |-> ##[1:3] high_gate_drive_o == 3'h0;
	endproperty
	a_trip: assert property (p_trip) else $error("Trip did not turn the high side off");
	property p_blank;
		$rose(|high_gate_drive_o) && pwm_i && brake_n_i && !coast_reset_i && !fault_o && !high_vds_over_i
			|=> (|high_gate_drive_o) [*3];
	endproperty
	a_blank: assert property (p_blank) else $error("High side dropped inside blanking");
	property p_short;
		(|high_gate_drive_o) && high_vds_over_i |-> ##[1:8] fault_src_o.short_gnd;
	endproperty
	a_short: assert property (p_short) else $error("Short to ground not flagged");
endmodule

bind bldc_commutation_protection_logic bldc_ctrl_properties #(
	.TMR_W(TMR_W)
) i_props (
	.clk_i(clk_i), .rstn_i(rstn_i), .pwm_i(pwm_i), .brake_n_i(brake_n_i), .coast_reset_i(coast_reset_i),
	.timing_i(timing_i), .current_trip_i(current_trip_i), .undervolt_i(undervolt_i), .overtemp_i(overtemp_i),
	.high_vds_over_i(high_vds_over_i), .high_gate_drive_o(high_gate_drive_o), .low_gate_drive_o(low_gate_drive_o),
	.fault_o(fault_o), .fault_src_o(fault_src_o)
);
`default_nettype wire

//--- tb/tb.sv
// Testbench driving the motor logic beside a bridge model and checking gates and status.
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam bldc_ctrl_pkg::timing_t TIMING = '{dead_cyc: 12'h002, off_cyc: 12'h014, blank_cyc: 12'h004};
	localparam logic [2:0] CODES [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	localparam logic [2:0] HI [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
	localparam logic [2:0] LO [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
	localparam logic [5:0] DECAY [4] = '{6'h00, 6'h04, 6'h21, 6'h05};

	// Inputs start idle with Halls on a legal code and PWM held high for current-limited control.
	logic                  clk_i = 1'b0;
	logic                  rstn_i = 1'b0;
	logic [2:0]            hall = 3'h5;
	logic                  dir = 1'b1;
	logic                  pwm = 1'b1;
	logic                  slow = 1'b1;
	logic                  sr = 1'b0;
	logic                  brake_n = 1'b1;
	logic                  coast = 1'b0;
	logic                  trip = 1'b0;
	logic                  uv = 1'b0;
	logic                  ot = 1'b0;
	logic                  short = 1'b0;
	logic                  vds_over, boot_busy, fault, speed_pulse_out;
	logic [2:0]            gate_hi, gate_lo;
	bldc_ctrl_pkg::fault_t fault_src;
	int                    error_cnt = 0;
	int                    tests_run = 0;
	int                    speed_pulse_out_cnt = 0;

	bldc_commutation_protection_logic i_dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .hall_inputs_i(hall), .dir_i(dir), .pwm_i(pwm), .decay_slow_i(slow),
		.sync_rectify_enable_i(sr), .brake_n_i(brake_n), .coast_reset_i(coast), .timing_i(TIMING),
		.current_trip_i(trip), .undervolt_i(uv), .overtemp_i(ot), .high_vds_over_i(vds_over),
		.boot_charge_busy_i(boot_busy), .high_gate_drive_o(gate_hi), .low_gate_drive_o(gate_lo),
		.fault_o(fault), .fault_src_o(fault_src), .speed_pulse_out_o(speed_pulse_out)
	);
	bridge_model i_bridge (
		.clk_i(clk_i), .high_gate_drive_i(gate_hi), .low_gate_drive_i(gate_lo), .short_i(short),
		.high_vds_over_o(vds_over), .boot_charge_busy_o(boot_busy)
	);

	// Speed pulses are counted at the sampling edge, one count per one-cycle pulse.
	always @(posedge clk_i) begin
		if (speed_pulse_out === 1'b1) begin
			speed_pulse_out_cnt <= speed_pulse_out_cnt + 1;
		end
	end

	// The clock runs at 10 MHz.
	initial begin
		forever #50 clk_i = ~clk_i;
	end

	// Inputs change on falling edges only, away from the sampling edge.
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Four-state compares, so an unknown never passes for a match.
	task automatic check_gates(input logic [5:0] exp);
		tests_run++;
		if ({gate_hi, gate_lo} !== exp) begin
			error_cnt++;
			$display("Error at %0t: gates %h expected %h", $time, {gate_hi, gate_lo}, exp);
		end
	endtask
	task automatic check_status(input logic [4:0] exp);
		tests_run++;
		if ({fault, fault_src} !== exp) begin
			error_cnt++;
			$display("Error at %0t: status %h expected %h", $time, {fault, fault_src}, exp);
		end
	endtask

	task automatic check_pulses(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			error_cnt++;
			$display("Error at %0t: pulses %h expected %h", $time, got, exp);
		end
	endtask

	task automatic t_commute();
		int pulses0;
		pulses0 = speed_pulse_out_cnt;
		for (int d = 1; d >= 0; d--) begin
			dir = d[0];
			for (int i = 0; i < 6; i++) begin
				hall = CODES[i];
				wait_cyc(30);
				check_gates(d[0] ? {HI[i], LO[i]} : {LO[i], HI[i]});
			end
		end
		wait_cyc(300);
		check_gates({LO[5], HI[5]});
		// The first code equals the idle code, so eleven of the twelve writes change the Halls.
		check_pulses(speed_pulse_out_cnt - pulses0, 11);
		$display("commutation done");
	endtask

	task automatic t_illegal();
		for (int c = 0; c < 8; c += 7) begin
			hall = c[2:0];
			wait_cyc(10);
			check_gates(6'h00);
			check_status(5'h18);
		end
		hall = 3'h5;
		dir = 1'b1;
		wait_cyc(30);
		check_status(5'h00);
		$display("illegal hall done");
	endtask

	// Undervolt masks the gates at once; over-temperature coasts and recovers.
	task automatic t_supply();
		uv = 1'b1;
		#1;
		check_gates(6'h00);
		wait_cyc(5);
		check_status(5'h14);
		uv = 1'b0;
		ot = 1'b1;
		wait_cyc(5);
		check_gates(6'h00);
		check_status(5'h12);
		ot = 1'b0;
		wait_cyc(30);
		check_gates(6'h0c);
		check_status(5'h00);
		$display("supply and thermal done");
	endtask

	task automatic t_brake();
		brake_n = 1'b0;
		wait_cyc(20);
		check_gates(6'h07);
		coast = 1'b1;
		wait_cyc(5);
		check_gates(6'h00);
		coast = 1'b0;
		brake_n = 1'b1;
		wait_cyc(30);
		check_gates(6'h0c);
		$display("brake done");
	endtask

	// Every decay and rectification pairing during PWM off.
	task automatic t_decay();
		pwm = 1'b0;
		for (int m = 0; m < 4; m++) begin
			slow = m[0];
			sr = m[1];
			wait_cyc(20);
			check_gates(DECAY[m]);
		end
		pwm = 1'b1;
		slow = 1'b1;
		sr = 1'b0;
		wait_cyc(30);
		$display("decay modes done");
	endtask

	task automatic t_chop();
		trip = 1'b1;
		wait_cyc(1);
		trip = 1'b0;
		wait_cyc(3);
		check_gates(6'h04);
		wait_cyc(12);
		check_gates(6'h04);
		wait_cyc(20);
		check_gates(6'h0c);
		trip = 1'b1;
		wait_cyc(3);
		for (int k = 0; k < 60 && gate_hi === 3'h0; k++) begin
			wait_cyc(1);
		end
		wait_cyc(2);
		check_gates(6'h0c);
		wait_cyc(10);
		check_gates(6'h04);
		trip = 1'b0;
		wait_cyc(40);
		$display("chopping done");
	endtask

	// A short trips the high side only; a new step or a coast pulse clears it.
	task automatic t_short();
		short = 1'b1;
		wait_cyc(10);
		check_status(5'h11);
		check_gates(6'h04);
		short = 1'b0;
		hall = 3'h4;
		wait_cyc(30);
		check_status(5'h00);
		short = 1'b1;
		wait_cyc(10);
		short = 1'b0;
		coast = 1'b1;
		wait_cyc(3);
		coast = 1'b0;
		wait_cyc(30);
		check_status(5'h00);
		check_gates(6'h14);
		$display("short to ground done");
	endtask

	// Halls tied to one legal code as for a two-phase load; direction alone sets polarity.
	task automatic t_hbridge();
		hall = 3'h6;
		dir = 1'b1;
		wait_cyc(30);
		check_gates(6'h11);
		dir = 1'b0;
		wait_cyc(30);
		check_gates(6'h0a);
		$display("h bridge done");
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Reset for eight cycles, then every scenario in turn.
	initial begin
		wait_cyc(8);
		rstn_i = 1'b1;
		wait_cyc(30);
		t_commute();
		t_illegal();
		t_supply();
		t_brake();
		t_decay();
		t_chop();
		t_short();
		t_hbridge();
		tally_and_finish();
	end

	// The scenarios need under 2000 cycles; a far larger span means a hang.
	initial begin
		wait_cyc(20000);
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
